// ### sim/ext_bus_memory.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_memory
(
	input wire logic clk,
	input wire logic [7:0] hi,
	input wire logic [7:0] c_out,
	input wire logic [7:0] c_oe,
	input wire logic al,
	input wire logic al_oe,
	input wire logic rw,
	output logic [7:0] c_pin
);
	logic [7:0] mem [0:65535];
	logic [15:0] adr_reg = 16'h0000;
	logic [7:0] last_reg = 8'h00;
	logic rd;
	assign rd = al_oe && !al && rw;
	// Released lines toggle so stale data never reads back as valid
	assign c_pin = (c_oe & c_out) | (~c_oe & (rd ? mem[adr_reg] : ~last_reg));
	always_ff @(posedge clk)
	begin
		last_reg <= c_pin;
		if (al_oe && al)
			adr_reg <= {hi, c_out};
		if (al_oe && !al && !rw && &c_oe)
			mem[adr_reg] <= c_out;
	end
endmodule
`default_nettype wire

// ### sim/pin_mux_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker
(
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic [7:0] PORTB_OUT,
	input wire logic [7:0] PORTC_OUT,
	input wire logic [7:0] PORTC_OE,
	input wire logic [5:0] PORTD_OUT,
	input wire logic [5:0] PORTD_OE,
	input wire logic STROBE_A_OUT,
	input wire logic STROBE_A_OE,
	input wire logic STROBE_B_OUT,
	input wire pin_mux_pkg::bus_cycle_s BUS,
	input wire logic [7:0] PORTB_GPIO,
	input wire pin_mux_pkg::gpio6_s PORTD_GPIO,
	input wire pin_mux_pkg::serial_ctl_s SERIAL_CTL,
	input wire pin_mux_pkg::spi_ctl_s SPI_CTL,
	input wire logic OUTPUT_HANDSHAKE_STROBE,
	input wire pin_mux_pkg::mode_e MODE,
	input wire logic EXPANDED_BUS
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	// Outputs still carry reset values on the first edge after release
	logic live_reg = 1'h0;
	logic bm;
	logic lk;
	always_ff @(posedge CORE_CLK)
		live_reg <= !RESET;
	assign bm = live_reg && EXPANDED_BUS;
	assign lk = MODE == pin_mux_pkg::MODE_SINGLE || MODE == pin_mux_pkg::MODE_EXPANDED;
	high_addr_a: assert property (
		bm |-> PORTB_OUT == $past(BUS.addr[15:8])) else $error("port B address wrong");
	low_addr_a: assert property (
		bm && !$past(BUS.data_phase) |-> PORTC_OE == 8'hFF && PORTC_OUT == $past(BUS.addr[7:0]))
		else $error("port C address wrong");
	read_release_a: assert property (
		bm && $past(BUS.data_phase && BUS.read) |-> PORTC_OE == 8'h00) else $error("port C driven");
	bus_strobes_a: assert property (
		bm |-> STROBE_A_OE && STROBE_A_OUT == $past(BUS.addr_latch)
		&& STROBE_B_OUT == $past(BUS.read)) else $error("bus strobes wrong");
	single_pins_a: assert property (
		live_reg && !EXPANDED_BUS |-> PORTB_OUT == $past(PORTB_GPIO) && !STROBE_A_OE
		&& STROBE_B_OUT == $past(OUTPUT_HANDSHAKE_STROBE)) else $error("single pins wrong");
	mode_lock_a: assert property (
		lk && live_reg && !$past(RESET, 2) |=> $stable(MODE)) else $error("locked mode moved");
	tx_drive_a: assert property (
		live_reg && $past(SERIAL_CTL.tx_enable && !PORTD_GPIO.wired_or)
		|-> PORTD_OE[1] && PORTD_OUT[1] == $past(SERIAL_CTL.txd)) else $error("tx pin wrong");
	gpio_d_a: assert property (
		live_reg && $past(SERIAL_CTL[2:1] == 2'h0 && !SPI_CTL.enable && !PORTD_GPIO.wired_or)
		|-> PORTD_OUT == $past(PORTD_GPIO.out) && PORTD_OE == $past(PORTD_GPIO.dir))
		else $error("port D gpio wrong");
	cover property (bm && $past(BUS.data_phase && BUS.read));
	cover property (MODE == pin_mux_pkg::MODE_BOOT);
	cover property (SPI_CTL.enable && SPI_CTL.master);
endmodule
bind port_pin_function_mux pin_mux_checker chk
(
	.CORE_CLK, .RESET, .PORTB_OUT, .PORTC_OUT, .PORTC_OE, .PORTD_OUT, .PORTD_OE,
	.STROBE_A_OUT, .STROBE_A_OE, .STROBE_B_OUT, .BUS, .PORTB_GPIO, .PORTD_GPIO,
	.SERIAL_CTL, .SPI_CTL, .OUTPUT_HANDSHAKE_STROBE, .MODE, .EXPANDED_BUS
);
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic ma = 1'h0;
	logic mb = 1'h1;
	logic sa = 1'h0;
	logic hs = 1'h0;
	logic [5:0] pd = 6'h00;
	logic [7:0] pe = 8'h00;
	logic [7:0] pbg = 8'h00;
	pin_mux_pkg::bus_cycle_s bus = '0;
	pin_mux_pkg::gpio8_s pcg = '0;
	pin_mux_pkg::gpio6_s pdg = '0;
	pin_mux_pkg::serial_ctl_s ser = '0;
	pin_mux_pkg::spi_ctl_s spi = '0;
	pin_mux_pkg::mode_wr_s mwr = '0;
	pin_mux_pkg::mode_e mode;
	pin_mux_pkg::spi_in_s spin;
	logic [7:0] pbo, pco, pcoe, pcp, rdat, pee, pcr;
	logic [5:0] pdo, pdoe, oe, ou, pdr;
	logic sao, saoe, sbo, xb, rxd, ihs;
	int n_fail = 0;
	int check_count = 0;
	int seed = 32'h9344922b;
	logic [31:0] r;
	logic [19:0] q [$];
	event look_e;
	wire logic [5:0] pdp = (pdoe & pdo) | (~pdoe & pd);
	port_pin_function_mux dut
	(
		.CORE_CLK(clk), .RESET(rst), .MODE_PIN_A(ma), .MODE_PIN_B(mb),
		.PORTB_OUT(pbo), .PORTC_IN(pcp), .PORTC_OUT(pco), .PORTC_OE(pcoe),
		.PORTD_IN(pdp), .PORTD_OUT(pdo), .PORTD_OE(pdoe), .PORTE_IN(pe),
		.STROBE_A_IN(sa), .STROBE_A_OUT(sao), .STROBE_A_OE(saoe), .STROBE_B_OUT(sbo),
		.BUS(bus), .PORTB_GPIO(pbg), .PORTC_GPIO(pcg), .PORTD_GPIO(pdg),
		.SERIAL_CTL(ser), .SPI_CTL(spi), .OUTPUT_HANDSHAKE_STROBE(hs), .MODE_WR(mwr),
		.MODE(mode), .EXPANDED_BUS(xb), .BUS_RDATA(rdat), .PORTC_RD(pcr), .PORTD_RD(pdr),
		.PORTE_RD(pee), .SERIAL_RXD(rxd), .SPI_IN(spin), .INPUT_HANDSHAKE_STROBE(ihs)
	);
	ext_bus_memory far
	(
		.clk(clk), .hi(pbo), .c_out(pco), .c_oe(pcoe),
		.al(sao), .al_oe(saoe), .rw(sbo), .c_pin(pcp)
	);
	initial
		forever #12.5 clk = ~clk;
	function automatic logic [15:0] got(input logic [3:0] s);
		case (s)
			0: got = {8'h00, pbo};
			1: got = {pcoe, pco};
			2: got = {13'h0000, saoe, saoe & sao, sbo};
			3: got = {13'h0000, xb, mode};
			4: got = {pcr, rdat};
			5: got = {7'h00, ihs, pee};
			6: got = {2'h0, pdoe, 2'h0, pdo};
			default: got = {4'h0, pdr, spin, rxd, 1'h0};
		endcase
	endfunction
	always @(look_e)
		while (q.size() > 0)
		begin
			check_count++;
			if (got(q[0][19:16]) !== q[0][15:0])
			begin
				n_fail++;
				$display("unexpected at %0t: view %0d is %h", $time, q[0][19:16], got(q[0][19:16]));
			end
			void'(q.pop_front());
		end
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task note(input logic [3:0] s, input logic [15:0] v);
		q.push_back({s, v});
		-> look_e;
	endtask
	task nd;
		note(6, {2'h0, oe, 2'h0, ou});
	endtask
	task close_out;
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task cyc(input logic [15:0] a, input logic [7:0] d, input logic rd, input int hold);
		bus = {a, 8'h00, rd, 2'h1};
		tick(1);
		note(0, {8'h00, a[15:8]});
		note(1, {8'hFF, a[7:0]});
		note(2, {13'h0000, 2'h3, rd});
		bus = {a, d, rd, 2'h2};
		tick(hold);
		note(1, rd ? 16'h0000 : {8'hFF, d});
		note(2, {13'h0000, 2'h2, rd});
	endtask
	task automatic mode_run(input logic [1:0] m);
		r = $random(seed);
		{mb, ma} = {~m[1], m[0]};
		rst = 1'h1;
		tick(6);
		rst = 1'h0;
		tick(2);
		note(3, {13'h0000, m[0], m});
		pbg = r[7:0];
		pcg = r[15:0];
		hs = r[16];
		bus = {r[31:16], 11'h001};
		tick(1);
		if (m[0])
		begin
			cyc(r[31:16], r[7:0], 1'h0, 1);
			cyc(r[31:16], 8'h00, 1'h1, 8);
			note(4, {r[7:0], r[7:0]});
		end
		else
		begin
			note(0, {8'h00, pbg});
			note(1, {pcg.dir, pcg.out});
			note(2, {13'h0000, 2'h0, hs});
		end
		pe = r[23:16];
		sa = r[24];
		tick(6);
		note(5, {7'h00, sa & ~m[0], pe});
		pdg = {r[11:0], 1'h0};
		tick(1);
		note(6, {2'h0, pdg.dir, 2'h0, pdg.out});
		mwr = {1'h1, pin_mux_pkg::MODE_EXPANDED};
		tick(1);
		mwr = '0;
		tick(2);
		note(3, m[1] ? 16'h0005 : {13'h0000, m[0], m});
	endtask
	initial
	begin
		tick(3);
		rst = 1'h0;
		tick(2);
		for (int m = 0; m < 4; m++)
			mode_run(m[1:0]);
		r = $random(seed);
		pd = 6'h00;
		ser = {2'h3, r[12]};
		tick(1);
		oe = pdg.dir & 6'h3C | 6'h02;
		ou = pdg.out & 6'h3D | {4'h0, r[12], 1'h0};
		nd;
		ser = '0;
		spi = {2'h3, r[15:13]};
		tick(1);
		oe = pdg.dir & 6'h03 | 6'h18;
		ou = pdg.out & 6'h27 | {1'h0, r[13], r[14], 3'h0};
		nd;
		spi.master = 1'h0;
		tick(6);
		oe = pdg.dir & 6'h03 | 6'h04;
		ou = pdg.out & 6'h3B | {3'h0, r[15], 2'h0};
		nd;
		pd = 6'h20;
		tick(6);
		oe = pdg.dir & 6'h03;
		nd;
		spi = '0;
		pdg.wired_or = 1'h1;
		tick(1);
		oe = pdg.dir & ~pdg.out;
		ou = pdg.out;
		nd;
		pdg = '0;
		pd = r[21:16];
		tick(6);
		note(7, {4'h0, pd, pd[2], pd[3], pd[4], pd[5], pd[0], 1'h0});
		tick(2);
		close_out;
	end
	initial
	begin
		repeat (2000) @(posedge clk);
		n_fail++;
		close_out;
	end
endmodule
`default_nettype wire

// ### verilog/pin_mux_pkg.sv
package pin_mux_pkg;

	typedef enum logic [1:0] {MODE_SINGLE, MODE_EXPANDED, MODE_BOOT, MODE_TEST} mode_e;

	// ------------------------------------------------------------------
	// Mode pin codes, mode_pin_b in the upper bit
	// ------------------------------------------------------------------
	localparam logic [1:0] PINS_SINGLE = 2'h2;
	localparam logic [1:0] PINS_EXPANDED = 2'h3;
	localparam logic [1:0] PINS_BOOT = 2'h0;
	localparam logic [1:0] PINS_TEST = 2'h1;

	// ------------------------------------------------------------------
	// Layout of the synchronised pin vector
	// ------------------------------------------------------------------
	localparam int PORTC_W = 8;
	localparam int PORTD_W = 6;
	localparam int PORTE_W = 8;
	localparam int SYNC_W = 25;
	localparam int SYNC_C_LSB = 0;
	localparam int SYNC_D_LSB = 8;
	localparam int SYNC_E_LSB = 14;
	localparam int SYNC_STROBE_A = 22;
	localparam int SYNC_MODE_A = 23;
	localparam int SYNC_MODE_B = 24;

	// ------------------------------------------------------------------
	// Port D bit positions
	// ------------------------------------------------------------------
	localparam int PD_RXD = 0;
	localparam int PD_TXD = 1;
	localparam int PD_MISO = 2;
	localparam int PD_MOSI = 3;
	localparam int PD_SCK = 4;
	localparam int PD_SS = 5;

	// ------------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------------
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [5:0] PORTD_RESET = 6'h00;
	localparam logic LINE_IDLE = 1'b1;
	localparam logic LINE_LOW = 1'b0;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic read;
		logic data_phase;
		logic addr_latch;
	} bus_cycle_s;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] dir;
	} gpio8_s;

	typedef struct packed {
		logic [5:0] out;
		logic [5:0] dir;
		logic wired_or;
	} gpio6_s;

	typedef struct packed {
		logic rx_enable;
		logic tx_enable;
		logic txd;
	} serial_ctl_s;

	typedef struct packed {
		logic enable;
		logic master;
		logic miso;
		logic mosi;
		logic sck;
	} spi_ctl_s;

	typedef struct packed {
		logic miso;
		logic mosi;
		logic sck;
		logic select_n;
	} spi_in_s;

	typedef struct packed {
		logic write;
		mode_e mode;
	} mode_wr_s;

endpackage

// ### verilog/port_pin_function_mux.sv
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_mux
(
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic MODE_PIN_A,
	input wire logic MODE_PIN_B,
	output logic [7:0] PORTB_OUT,
	input wire logic [7:0] PORTC_IN,
	output logic [7:0] PORTC_OUT,
	output logic [7:0] PORTC_OE,
	input wire logic [5:0] PORTD_IN,
	output logic [5:0] PORTD_OUT,
	output logic [5:0] PORTD_OE,
	input wire logic [7:0] PORTE_IN,
	input wire logic STROBE_A_IN,
	output logic STROBE_A_OUT,
	output logic STROBE_A_OE,
	output logic STROBE_B_OUT,
	input wire pin_mux_pkg::bus_cycle_s BUS,
	input wire logic [7:0] PORTB_GPIO,
	input wire pin_mux_pkg::gpio8_s PORTC_GPIO,
	input wire pin_mux_pkg::gpio6_s PORTD_GPIO,
	input wire pin_mux_pkg::serial_ctl_s SERIAL_CTL,
	input wire pin_mux_pkg::spi_ctl_s SPI_CTL,
	input wire logic OUTPUT_HANDSHAKE_STROBE,
	input wire pin_mux_pkg::mode_wr_s MODE_WR,
	output pin_mux_pkg::mode_e MODE,
	output logic EXPANDED_BUS,
	output logic [7:0] BUS_RDATA,
	output logic [7:0] PORTC_RD,
	output logic [5:0] PORTD_RD,
	output logic [7:0] PORTE_RD,
	output logic SERIAL_RXD,
	output pin_mux_pkg::spi_in_s SPI_IN,
	output logic INPUT_HANDSHAKE_STROBE
);

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------
	function automatic pin_mux_pkg::mode_e mode_from_pins(input logic [1:0] pins);
		pin_mux_pkg::mode_e m;
		m = pin_mux_pkg::MODE_SINGLE;
		unique case (pins)
			pin_mux_pkg::PINS_SINGLE: m = pin_mux_pkg::MODE_SINGLE;
			pin_mux_pkg::PINS_EXPANDED: m = pin_mux_pkg::MODE_EXPANDED;
			pin_mux_pkg::PINS_BOOT: m = pin_mux_pkg::MODE_BOOT;
			pin_mux_pkg::PINS_TEST: m = pin_mux_pkg::MODE_TEST;
		endcase
		return m;
	endfunction

	// Bootstrap shares the single-chip pinout, test shares the expanded one
	function automatic logic bus_on(input pin_mux_pkg::mode_e m);
		logic on;
		on = 1'b0;
		unique case (m)
			pin_mux_pkg::MODE_SINGLE: on = 1'b0;
			pin_mux_pkg::MODE_BOOT: on = 1'b0;
			pin_mux_pkg::MODE_EXPANDED: on = 1'b1;
			pin_mux_pkg::MODE_TEST: on = 1'b1;
		endcase
		return on;
	endfunction

	function automatic logic is_special(input pin_mux_pkg::mode_e m);
		return (m == pin_mux_pkg::MODE_BOOT) || (m == pin_mux_pkg::MODE_TEST);
	endfunction

	// ------------------------------------------------------------------
	// Pin input synchroniser
	// ------------------------------------------------------------------
	logic [pin_mux_pkg::SYNC_W-1:0] pins_raw;
	logic [pin_mux_pkg::SYNC_W-1:0] sync1_reg;
	logic [pin_mux_pkg::SYNC_W-1:0] sync2_reg;
	logic [pin_mux_pkg::SYNC_W-1:0] sync3_reg;
	logic [pin_mux_pkg::SYNC_W-1:0] pins_reg;
	logic [pin_mux_pkg::SYNC_W-1:0] pins_next;

	assign pins_raw = {MODE_PIN_B, MODE_PIN_A, STROBE_A_IN, PORTE_IN, PORTD_IN, PORTC_IN};

	// A bit moves only once stages two and three agree, so a pin caught
	// mid-transition is never seen as a glitch
	assign pins_next = (sync2_reg & sync3_reg) | (pins_reg & (sync2_reg ^ sync3_reg));

	// Left free of reset so the mode pins can settle while reset is held
	always_ff @(posedge CORE_CLK)
	begin
		sync1_reg <= pins_raw;
		sync2_reg <= sync1_reg;
		sync3_reg <= sync2_reg;
		pins_reg <= pins_next;
	end

	logic [7:0] pc_s;
	logic [5:0] pd_s;
	logic [7:0] pe_s;
	logic [1:0] mode_pins_s;

	assign pc_s = pins_reg[pin_mux_pkg::SYNC_C_LSB +: pin_mux_pkg::PORTC_W];
	assign pd_s = pins_reg[pin_mux_pkg::SYNC_D_LSB +: pin_mux_pkg::PORTD_W];
	assign pe_s = pins_reg[pin_mux_pkg::SYNC_E_LSB +: pin_mux_pkg::PORTE_W];
	assign mode_pins_s = {pins_reg[pin_mux_pkg::SYNC_MODE_B], pins_reg[pin_mux_pkg::SYNC_MODE_A]};

	// ------------------------------------------------------------------
	// Operating mode
	// ------------------------------------------------------------------
	pin_mux_pkg::mode_e mode_reg;
	logic bus_mode;

	// Software may only leave a special mode; normal modes stay locked
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			mode_reg <= mode_from_pins(mode_pins_s);
		end
		else if (MODE_WR.write && is_special(mode_reg))
		begin
			mode_reg <= MODE_WR.mode;
		end
	end

	assign bus_mode = bus_on(mode_reg);

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			MODE <= pin_mux_pkg::MODE_SINGLE;
			EXPANDED_BUS <= 1'b0;
		end
		else
		begin
			MODE <= mode_reg;
			EXPANDED_BUS <= bus_mode;
		end
	end

	// ------------------------------------------------------------------
	// Ports B, C and strobes
	// ------------------------------------------------------------------
	logic [7:0] pb_next;
	logic [7:0] pc_out_next;
	logic [7:0] pc_oe_next;
	logic input_handshake_strobe_out_next;
	logic input_handshake_strobe_oe_next;
	logic output_handshake_strobe_next;

	always_comb
	begin
		pb_next = PORTB_GPIO;
		pc_out_next = PORTC_GPIO.out;
		pc_oe_next = PORTC_GPIO.dir;
		input_handshake_strobe_out_next = pin_mux_pkg::LINE_LOW;
		input_handshake_strobe_oe_next = 1'b0;
		output_handshake_strobe_next = OUTPUT_HANDSHAKE_STROBE;
		if (bus_mode)
		begin
			// Core presents a cycle every clock, internal targets included
			pb_next = BUS.addr[15:8];
			input_handshake_strobe_out_next = BUS.addr_latch;
			input_handshake_strobe_oe_next = 1'b1;
			output_handshake_strobe_next = BUS.read;
			if (!BUS.data_phase)
			begin
				pc_out_next = BUS.addr[7:0];
				pc_oe_next = 8'hFF;
			end
			else if (!BUS.read)
			begin
				pc_out_next = BUS.wdata;
				pc_oe_next = 8'hFF;
			end
			else
			begin
				pc_out_next = pin_mux_pkg::BYTE_RESET;
				pc_oe_next = 8'h00;
			end
		end
	end

	// Outside bus modes port B and C only follow the I/O values
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			PORTB_OUT <= pin_mux_pkg::BYTE_RESET;
			PORTC_OUT <= pin_mux_pkg::BYTE_RESET;
			PORTC_OE <= pin_mux_pkg::BYTE_RESET;
			STROBE_A_OUT <= pin_mux_pkg::LINE_LOW;
			STROBE_A_OE <= 1'b0;
			STROBE_B_OUT <= pin_mux_pkg::LINE_IDLE;
		end
		else
		begin
			PORTB_OUT <= pb_next;
			PORTC_OUT <= pc_out_next;
			PORTC_OE <= pc_oe_next;
			STROBE_A_OUT <= input_handshake_strobe_out_next;
			STROBE_A_OE <= input_handshake_strobe_oe_next;
			STROBE_B_OUT <= output_handshake_strobe_next;
		end
	end

	// Read data passes the pin synchroniser, so it trails the pins by
	// about five clocks; the data phase must last longer than that
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			BUS_RDATA <= pin_mux_pkg::BYTE_RESET;
		end
		else if (bus_mode && BUS.data_phase && BUS.read)
		begin
			BUS_RDATA <= pc_s;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			PORTC_RD <= pin_mux_pkg::BYTE_RESET;
			INPUT_HANDSHAKE_STROBE <= pin_mux_pkg::LINE_LOW;
		end
		else
		begin
			PORTC_RD <= pc_s;
			INPUT_HANDSHAKE_STROBE <= bus_mode ? pin_mux_pkg::LINE_LOW
				: pins_reg[pin_mux_pkg::SYNC_STROBE_A];
		end
	end

	// ------------------------------------------------------------------
	// Port D, independent of mode
	// ------------------------------------------------------------------
	logic [5:0] pd_out_next;
	logic [5:0] pd_oe_next;
	logic [5:0] pd_oe_final;

	always_comb
	begin
		pd_out_next = PORTD_GPIO.out;
		pd_oe_next = PORTD_GPIO.dir;
		if (SERIAL_CTL.rx_enable)
		begin
			pd_oe_next[pin_mux_pkg::PD_RXD] = 1'b0;
		end
		if (SERIAL_CTL.tx_enable)
		begin
			pd_out_next[pin_mux_pkg::PD_TXD] = SERIAL_CTL.txd;
			pd_oe_next[pin_mux_pkg::PD_TXD] = 1'b1;
		end
		if (SPI_CTL.enable)
		begin
			pd_oe_next[pin_mux_pkg::PD_SS] = 1'b0;
			if (SPI_CTL.master)
			begin
				pd_oe_next[pin_mux_pkg::PD_MISO] = 1'b0;
				pd_out_next[pin_mux_pkg::PD_MOSI] = SPI_CTL.mosi;
				pd_oe_next[pin_mux_pkg::PD_MOSI] = 1'b1;
				pd_out_next[pin_mux_pkg::PD_SCK] = SPI_CTL.sck;
				pd_oe_next[pin_mux_pkg::PD_SCK] = 1'b1;
			end
			else
			begin
				// A slave drives MISO only while selected, so several
				// slaves can share the line
				pd_out_next[pin_mux_pkg::PD_MISO] = SPI_CTL.miso;
				pd_oe_next[pin_mux_pkg::PD_MISO] = ~pd_s[pin_mux_pkg::PD_SS];
				pd_oe_next[pin_mux_pkg::PD_MOSI] = 1'b0;
				pd_oe_next[pin_mux_pkg::PD_SCK] = 1'b0;
			end
		end
	end

	// Wired-OR releases a driven high so an external pull-up supplies it
	assign pd_oe_final = PORTD_GPIO.wired_or ? (pd_oe_next & ~pd_out_next) : pd_oe_next;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			PORTD_OUT <= pin_mux_pkg::PORTD_RESET;
			PORTD_OE <= pin_mux_pkg::PORTD_RESET;
		end
		else
		begin
			PORTD_OUT <= pd_out_next;
			PORTD_OE <= pd_oe_final;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			PORTD_RD <= pin_mux_pkg::PORTD_RESET;
			SERIAL_RXD <= pin_mux_pkg::LINE_IDLE;
			SPI_IN <= {pin_mux_pkg::LINE_LOW, pin_mux_pkg::LINE_LOW,
				pin_mux_pkg::LINE_LOW, pin_mux_pkg::LINE_IDLE};
		end
		else
		begin
			PORTD_RD <= pd_s;
			SERIAL_RXD <= pd_s[pin_mux_pkg::PD_RXD];
			SPI_IN <= {pd_s[pin_mux_pkg::PD_MISO], pd_s[pin_mux_pkg::PD_MOSI],
				pd_s[pin_mux_pkg::PD_SCK], pd_s[pin_mux_pkg::PD_SS]};
		end
	end

	// ------------------------------------------------------------------
	// Port E, input only
	// ------------------------------------------------------------------
	// No drive exists here; the analog path taps the pins outside this block
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			PORTE_RD <= pin_mux_pkg::BYTE_RESET;
		end
		else
		begin
			PORTE_RD <= pe_s;
		end
	end

endmodule
`default_nettype wire
